/* core/rst_consts.svh */
// Offsets, field positions, clock rates and timing counts of the reset block
`ifndef RST_CONSTS_SVH
`define RST_CONSTS_SVH
`define ADDR_CAUSE      4'h0
`define ADDR_DOG_CTRL   4'h1
`define ADDR_REF_CTRL   4'h2
`define ADDR_RST_STATE  4'h3
`define BIT_DEBUG_FLAG  4
`define BIT_DOG_FLAG    3
`define BIT_LOW_FLAG    2
`define BIT_PIN_FLAG    1
`define BIT_UP_FLAG     0
`define BIT_UNLOCK      4
`define BIT_DOG_EN      3
`define UNLOCK_CYCLES   3'h4
`define DOG_BASE_CYCLES 32'h0000_4000
`define SYS_CLK_HZ      10000000
`define DOG_OSC_HZ      1000000
`define DOG_OSC_DIV     (`SYS_CLK_HZ / `DOG_OSC_HZ)
`define STARTUP_SHORT   16'h0010
`define STARTUP_LONG    16'h0400
`endif

/* core/rst_pkg.sv */
// Types shared by the reset block
package rst_pkg;
  typedef enum logic [1:0] {
    SEQ_HOLD  = 2'b00,
    SEQ_DELAY = 2'b01,
    SEQ_RUN   = 2'b11
  } seq_state_t;
endpackage

/* core/dog_if.sv */
// Watchdog control and status between top and watchdog counter
`timescale 1ns/1ps
`default_nettype none
interface dog_if;
  logic       enable;
  logic       kick;
  logic [2:0] prescale;
  logic       expire;
  modport ctrl (output enable, output kick, output prescale, input expire);
  modport dog  (input enable, input kick, input prescale, output expire);
endinterface
`default_nettype wire

/* core/dog_counter.sv */
// Watchdog counter ticking on its own 1 MHz enable
`timescale 1ns/1ps
`default_nettype none
`include "rst_consts.svh"
module dog_counter
  import rst_pkg::*;
#(
  parameter int DIV = `DOG_OSC_DIV
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic chip_rst,
  dog_if.dog        bus
);
  initial begin
    if (DIV < 1 || DIV > 256) $error("DIV must be 1 to 256");
  end

  typedef struct packed {
    logic [7:0]  div;
    logic [31:0] cnt;
    logic        expire;
  } dog_state_t;

  dog_state_t s_q;
  dog_state_t s_d;
  logic       tick;

  assign tick = (s_q.div == 8'(DIV - 1));

  function automatic logic [31:0] limit(input logic [2:0] p);
    limit = `DOG_BASE_CYCLES << p;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.expire = 1'b0;
    // (RULE_13) own oscillator tick
    if (s_q.div == 8'(DIV - 1)) begin
      s_d.div = 8'h00;
    end else begin
      s_d.div = s_q.div + 8'h01;
    end
    if (bus.enable && s_q.div == 8'(DIV - 1)) begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
    // (RULE_15) expiry at selected period
    if (bus.enable && tick && s_q.cnt >= limit(bus.prescale) - 32'h1) begin
      s_d.expire = 1'b1;
      s_d.cnt    = 32'h0000_0000;
    end
    // (RULE_14) kick, disable, chip reset
    if (bus.kick || !bus.enable || chip_rst) begin
      s_d.cnt    = 32'h0000_0000;
      s_d.expire = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.expire = s_q.expire;

  // (RULE_15) expiry lasts one cycle
  chk_expire_single: assert property (@(posedge clk) disable iff (!nrst)
    s_q.expire |=> !s_q.expire) else $error("expire longer than one"); // RULE_15
  // (RULE_14) kick clears the count
  chk_kick_clears: assert property (@(posedge clk) disable iff (!nrst)
    bus.kick |=> s_q.cnt == 32'h0) else $error("kick did not clear"); // RULE_14
  cov_expire: cover property (@(posedge clk) disable iff (!nrst) s_q.expire);
endmodule
`default_nettype wire

/* core/startup_delay.sv */
// Start-up delay counter that stretches the internal reset
`timescale 1ns/1ps
`default_nettype none
`include "rst_consts.svh"
module startup_delay
  import rst_pkg::*;
#(
  parameter logic [15:0] SHORT = `STARTUP_SHORT,
  parameter logic [15:0] LONG  = `STARTUP_LONG
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic any_src,
  input  wire logic long_sel,
  output logic      hold
);
  initial begin
    if (SHORT == 16'h0 || LONG == 16'h0) $error("delay must be nonzero");
  end

  typedef struct packed {
    seq_state_t  st;
    logic [15:0] cnt;
  } dly_state_t;

  dly_state_t s_q;
  dly_state_t s_d;

  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      SEQ_HOLD: begin
        s_d.cnt = 16'h0;
        if (!any_src) begin
          s_d.st = SEQ_DELAY;
        end
      end
      SEQ_DELAY: begin
        s_d.cnt = s_q.cnt + 16'h1;
        // (RULE_21) fuse picks delay length
        if (s_q.cnt == (long_sel ? LONG : SHORT) - 16'h1) begin
          s_d.st = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        s_d.cnt = 16'h0;
      end
      default: begin
        s_d.st = SEQ_HOLD;
      end
    endcase
    // (RULE_24) restart on reassertion
    if (any_src) begin
      s_d.st  = SEQ_HOLD;
      s_d.cnt = 16'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{st: SEQ_HOLD, cnt: 16'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign hold = (s_q.st != SEQ_RUN) || any_src;

  // (RULE_24) source forces hold
  chk_src_holds: assert property (@(posedge clk) disable iff (!nrst)
    any_src |=> (s_q.st == SEQ_HOLD && s_q.cnt == 16'h0))
    else $error("reset not held"); // RULE_24
  cov_release: cover property (@(posedge clk) disable iff (!nrst)
    $fell(hold));
endmodule
`default_nettype wire

/* core/reset_sources_and_watchdog.sv */
// Reset source collection, cause flags, bandgap enable and watchdog control
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rst_consts.svh"

// Notes on behaviour
// (RULE_01) Supply-up detector low forces reset at once; release starts delay.
// (RULE_02) Low reset pin resets without clock; release then waits delay.
// (RULE_03) Enabled low-supply detector resets at once; clear then waits delay.
// (RULE_04) Watchdog expiry gives one-cycle pulse; delay starts after it.
// (RULE_05) Debug flag bit 4 sets on debug reset; clears on power-up or zero.
// (RULE_06) Watchdog flag bit 3 sets on watchdog reset; same clearing.
// (RULE_07) Low-supply flag bit 2 sets on low-supply reset; same clearing.
// (RULE_08) Pin flag bit 1 sets on pin reset; same clearing.
// (RULE_09) Power-up flag bit 0 sets on power-up; cleared only by software.
// (RULE_10) Software should read then clear cause flags early.
// (RULE_11) Reference on when detector fuse, comparator select or converter.
// (RULE_12) Software waits reference start-up before using results.
// (RULE_13) Watchdog counts its own 1 MHz tick.
// (RULE_14) Kick, disable and chip reset clear watchdog counter.
// (RULE_15) Unkicked enabled watchdog at period causes reset.
// (RULE_16) Control bits 7..5 read zero.
// (RULE_17) Unlock bit clears itself four cycles after set.
// (RULE_18) Enable set by one; cleared by zero only while unlocked.
// (RULE_19) Software writes unlock+enable, then zero within four cycles.
// (RULE_20) Prescale picks 16384 cycles doubled per step.
// (RULE_21) Start-up delay length chosen by clock-select fuses.
// (RULE_22) Debug reset register held one keeps device in reset.
// (RULE_23) Port reset goes active at once without clock.
// (RULE_24) Reassertion during delay holds reset and restarts count.
module reset_sources_and_watchdog
  import rst_pkg::*;
#(
  parameter int DOG_DIV = `DOG_OSC_DIV
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       supply_up_ok,
  input  wire logic       reset_pin_n,
  input  wire logic       low_supply_detector,
  input  wire logic       low_supply_detect_fuse,
  input  wire logic       debug_reset_instruction,
  input  wire logic       clock_select_fuses,
  input  wire logic       converter_enable,
  input  wire logic       dog_kick_instruction,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            core_rst_n,
  output logic            port_rst_n,
  output logic            bandgap_enable
);
  initial begin
    if (DOG_DIV < 1 || DOG_DIV > 256) $error("DOG_DIV must be 1 to 256");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] pin_sync_q;
  logic [1:0] up_sync_q;
  logic [1:0] low_sync_q;
  logic [1:0] dbg_sync_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_sync_q <= 2'h0;
      up_sync_q  <= 2'h0;
      low_sync_q <= 2'h0;
      dbg_sync_q <= 2'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], reset_pin_n};
      up_sync_q  <= {up_sync_q[0], supply_up_ok};
      low_sync_q <= {low_sync_q[0], low_supply_detector};
      dbg_sync_q <= {dbg_sync_q[0], debug_reset_instruction};
    end
  end

  logic pin_src;
  logic up_src;
  logic low_src;
  logic dbg_src;

  assign pin_src = !pin_sync_q[1];
  assign up_src  = !up_sync_q[1];
  assign low_src = low_supply_detect_fuse && low_sync_q[1];
  assign dbg_src = dbg_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Clockless reset paths

  // (RULE_23) ports reset without clock
  assign port_rst_n = nrst && reset_pin_n && supply_up_ok
    && !(low_supply_detect_fuse && low_supply_detector)
    && !debug_reset_instruction;

  ////////////////////////////////////////////////////////////////////////////
  // Block state

  typedef struct packed {
    logic [4:0] cause;
    logic       unlock;
    logic [2:0] unlock_cnt;
    logic       dog_en;
    logic [2:0] prescale;
    logic       cmp_bg_sel;
    logic       dog_pulse;
    logic [7:0] rdata;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  dog_if dog_bus ();
  logic  dly_hold;
  logic  any_src;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
    hit = (a == ref_a);
  endfunction

  logic wr_cause;
  logic wr_ctrl;
  logic wr_ref;

  assign wr_cause = wr && hit(addr, `ADDR_CAUSE);
  assign wr_ctrl  = wr && hit(addr, `ADDR_DOG_CTRL);
  assign wr_ref   = wr && hit(addr, `ADDR_REF_CTRL);

  always_comb begin
    s_d = s_q;
    s_d.dog_pulse = 1'b0;
    s_d.rdata     = 8'h00;

    // Software clears cause flags by writing zero
    if (wr_cause) begin
      s_d.cause = s_q.cause & wdata[4:0];
    end
    // (RULE_09) power-up flag
    if (up_src) begin
      s_d.cause = 5'h01;
    end else begin
      // (RULE_08) pin reset flag
      if (pin_src) begin
        s_d.cause[`BIT_PIN_FLAG] = 1'b1;
      end
      // (RULE_07) low-supply flag
      if (low_src) begin
        s_d.cause[`BIT_LOW_FLAG] = 1'b1;
      end
      // (RULE_06) watchdog reset flag
      if (s_q.dog_pulse) begin
        s_d.cause[`BIT_DOG_FLAG] = 1'b1;
      end
      // (RULE_05) debug reset flag
      if (dbg_src) begin
        s_d.cause[`BIT_DEBUG_FLAG] = 1'b1;
      end
    end

    // (RULE_17) unlock clears after four cycles
    if (s_q.unlock) begin
      s_d.unlock_cnt = s_q.unlock_cnt + 3'h1;
      if (s_q.unlock_cnt == `UNLOCK_CYCLES - 3'h1) begin
        s_d.unlock     = 1'b0;
        s_d.unlock_cnt = 3'h0;
      end
    end
    if (wr_ctrl) begin
      s_d.prescale = wdata[2:0];
      // (RULE_18) protected enable
      if (wdata[`BIT_DOG_EN]) begin
        s_d.dog_en = 1'b1;
      end else if (s_q.unlock) begin
        s_d.dog_en = 1'b0;
      end
      if (wdata[`BIT_UNLOCK]) begin
        s_d.unlock     = 1'b1;
        s_d.unlock_cnt = 3'h0;
      end
    end
    if (wr_ref) begin
      s_d.cmp_bg_sel = wdata[0];
    end

    // (RULE_04) one-cycle watchdog pulse
    if (dog_bus.expire) begin
      s_d.dog_pulse = 1'b1;
    end

    if (rd) begin
      unique case (addr)
        `ADDR_CAUSE:     s_d.rdata = {3'h0, s_q.cause};
        // (RULE_16) reserved bits read zero
        `ADDR_DOG_CTRL:  s_d.rdata = {3'h0, s_q.unlock, s_q.dog_en,
                                      s_q.prescale};
        `ADDR_REF_CTRL:  s_d.rdata = {7'h00, s_q.cmp_bg_sel};
        `ADDR_RST_STATE: s_d.rdata = {6'h00, bandgap_enable, dly_hold};
        default:         s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog and start-up delay

  assign dog_bus.enable   = s_q.dog_en;
  // (RULE_14) kick clears counter
  assign dog_bus.kick     = dog_kick_instruction;
  // (RULE_20) prescale selection
  assign dog_bus.prescale = s_q.prescale;

  dog_counter #(
    .DIV (DOG_DIV)
  ) u_dog (
    .clk      (clk),
    .nrst     (nrst),
    .chip_rst (!core_rst_n),
    .bus      (dog_bus)
  );

  // (RULE_01) supply-up, (RULE_02) pin, (RULE_03) low supply, (RULE_22) debug
  assign any_src = up_src || pin_src || low_src || dbg_src || s_q.dog_pulse;

  startup_delay u_dly (
    .clk      (clk),
    .nrst     (nrst),
    .any_src  (any_src),
    .long_sel (clock_select_fuses),
    .hold     (dly_hold)
  );

  // (RULE_02) pin acts without clock via port reset
  assign core_rst_n = port_rst_n && !dly_hold;

  // (RULE_11) bandgap enable
  assign bandgap_enable = low_supply_detect_fuse || s_q.cmp_bg_sel
    || converter_enable;

  assign rdata = s_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // (RULE_17) unlock lasts four cycles
  chk_unlock_clear: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ctrl && wdata[4]) |=> s_q.unlock [*4] ##1 !s_q.unlock)
    else $error("unlock not cleared on time"); // RULE_17
  // (RULE_18) locked enable stays set
  chk_enable_locked: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ctrl && !wdata[3] && !s_q.unlock && s_q.dog_en) |=> s_q.dog_en)
    else $error("enable cleared while locked"); // RULE_18
  // (RULE_04) pulse is one cycle
  chk_dog_pulse: assert property (@(posedge clk) disable iff (!nrst)
    dog_bus.expire |=> s_q.dog_pulse ##1 !s_q.dog_pulse)
    else $error("watchdog pulse wrong"); // RULE_04
  // (RULE_06) watchdog flag follows pulse
  chk_dog_flag: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.dog_pulse && !up_src) |=> s_q.cause[3])
    else $error("watchdog flag not set"); // RULE_06
  // (RULE_09) power-up sets only its flag
  chk_up_flag: assert property (@(posedge clk) disable iff (!nrst)
    up_src |=> s_q.cause == 5'h01) else $error("power-up flags wrong"); // RULE_09
  // (RULE_08) pin flag set
  chk_pin_flag: assert property (@(posedge clk) disable iff (!nrst)
    (pin_src && !up_src) |=> s_q.cause[1]) else $error("pin flag"); // RULE_08
  // (RULE_07) low flag set
  chk_low_flag: assert property (@(posedge clk) disable iff (!nrst)
    (low_src && !up_src) |=> s_q.cause[2]) else $error("low flag"); // RULE_07
  // (RULE_05) debug flag set
  chk_dbg_flag: assert property (@(posedge clk) disable iff (!nrst)
    (dbg_src && !up_src) |=> s_q.cause[4]) else $error("debug flag"); // RULE_05
  // (RULE_22) debug holds reset
  chk_dbg_hold: assert property (@(posedge clk) disable iff (!nrst)
    dbg_src |-> !core_rst_n) else $error("debug not held"); // RULE_22
  // (RULE_16) reserved bits zero
  chk_reserved: assert property (@(posedge clk) disable iff (!nrst)
    $past(rd) && $past(addr) == `ADDR_DOG_CTRL |-> rdata[7:5] == 3'h0)
    else $error("reserved bits nonzero"); // RULE_16
  // (RULE_11) comparator select turns bandgap on
  chk_bandgap: assert property (@(posedge clk) disable iff (!nrst)
    s_q.cmp_bg_sel |-> bandgap_enable) else $error("bandgap off"); // RULE_11

  // (RULE_01) supply drop resets ports
  chk_up_port: assert property ( // RULE_01
    @(posedge clk) disable iff (!nrst) !supply_up_ok |-> !port_rst_n)
    else $error("supply drop ignored");
  // (RULE_02) low pin resets ports
  chk_pin_port: assert property ( // RULE_02
    @(posedge clk) disable iff (!nrst) !reset_pin_n |-> !port_rst_n)
    else $error("pin low ignored");
  // (RULE_03) fused detector resets ports
  chk_low_port: assert property ( // RULE_03
    @(posedge clk) disable iff (!nrst)
    (low_supply_detect_fuse && low_supply_detector) |-> !port_rst_n)
    else $error("low supply ignored");
  // (RULE_24) any source holds core
  chk_any_hold: assert property ( // RULE_24
    @(posedge clk) disable iff (!nrst) any_src |-> !core_rst_n)
    else $error("core released under source");
  // (RULE_15) expiry resets core
  chk_dog_reset: assert property ( // RULE_15
    @(posedge clk) disable iff (!nrst) s_q.dog_pulse |-> !core_rst_n)
    else $error("expiry did not reset");
  // (RULE_18) enable set by one
  chk_enable_set: assert property ( // RULE_18
    @(posedge clk) disable iff (!nrst)
    (wr_ctrl && wdata[`BIT_DOG_EN]) |=> s_q.dog_en)
    else $error("enable not set");
  // (RULE_18) unlocked zero clears enable
  chk_enable_clear: assert property ( // RULE_18
    @(posedge clk) disable iff (!nrst)
    (wr_ctrl && !wdata[`BIT_DOG_EN] && s_q.unlock) |=> !s_q.dog_en)
    else $error("enable not cleared");
  // (RULE_20) prescale written
  chk_prescale_wr: assert property ( // RULE_20
    @(posedge clk) disable iff (!nrst)
    wr_ctrl |=> s_q.prescale == $past(wdata[2:0]))
    else $error("prescale not stored");
  // (RULE_09) power-up flag cleared by zero
  chk_up_clear: assert property ( // RULE_09
    @(posedge clk) disable iff (!nrst)
    (wr_cause && !wdata[`BIT_UP_FLAG] && !up_src) |=> !s_q.cause[0])
    else $error("power-up flag not cleared");
  // (RULE_09) power-up flag sticky
  chk_up_sticky: assert property ( // RULE_09
    @(posedge clk) disable iff (!nrst)
    (s_q.cause[0] && !wr_cause) |=> s_q.cause[0])
    else $error("power-up flag lost");
  // Read data only after a read
  chk_rd_idle: assert property (
    @(posedge clk) disable iff (!nrst) !$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read");

  cov_dog_off: cover property (@(posedge clk) disable iff (!nrst)
    $fell(s_q.dog_en));
  cov_pin_reset: cover property (@(posedge clk) disable iff (!nrst)
    pin_src ##[1:50] core_rst_n);
  cov_flag_clear: cover property (@(posedge clk) disable iff (!nrst)
    wr_cause && wdata == 8'h00);
endmodule
`default_nettype wire

/* tb/supply_pins_model.sv */
// Supply detectors, reset pin and debug reset register model
`timescale 1ns/1ps
`default_nettype none
module supply_pins_model (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [3:0] req,
  output logic            supply_up_ok,
  output logic            reset_pin_n,
  output logic            low_supply_detector,
  output logic            debug_reset_instruction
);
  logic [3:0] lvl = 4'h1;
  // Sources go active at once; slow release lags three cycles
  always @(req) begin
    lvl = lvl | req;
    if (slow) begin
      repeat (3) @(negedge clk);
    end
    lvl = req;
  end
  assign supply_up_ok            = ~lvl[0];
  assign reset_pin_n             = ~lvl[1];
  assign low_supply_detector     = lvl[2];
  assign debug_reset_instruction = lvl[3];
endmodule
`default_nettype wire

/* tb/reset_sources_and_watchdog_bench.sv */
// Self-checking bench of the reset sources and watchdog block
`timescale 1ns/1ps
`default_nettype none
module reset_sources_and_watchdog_bench;
  logic       clk = 1'b0;
  logic       nrst, slow, fuse, csel, conv, kick, wr, rd, comparator_bandgap_select;
  logic [3:0] req, addr;
  logic [7:0] wdata, rdata;
  logic       up_ok, pin_n, low_det, dbg, core_n, port_n, bg;
  int         n_fail = 0;
  int         n_compared = 0;
  int         i, n;

  always #50 clk = ~clk;

  supply_pins_model partner (.clk(clk), .slow(slow), .req(req),
    .supply_up_ok(up_ok), .reset_pin_n(pin_n),
    .low_supply_detector(low_det), .debug_reset_instruction(dbg));

  reset_sources_and_watchdog #(.DOG_DIV(1)) DUT (.clk(clk), .nrst(nrst),
    .supply_up_ok(up_ok), .reset_pin_n(pin_n),
    .low_supply_detector(low_det), .low_supply_detect_fuse(fuse),
    .debug_reset_instruction(dbg), .clock_select_fuses(csel),
    .converter_enable(conv), .dog_kick_instruction(kick),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .core_rst_n(core_n), .port_rst_n(port_n), .bandgap_enable(bg));

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp,
                        input string what);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata, exp, what);
  endtask

  // Bounded wait for core start, which must not come before lo cycles
  task automatic wait_run(input int lo);
    int c;
    c = 0;
    while (core_n !== 1'b1 && c < 2000) begin
      @(posedge clk);
      c++;
    end
    if (c >= 2000) begin
      n_fail++;
      $display("Error at %0t: core reset never released", $time);
      close_out();
    end
    check({7'h0, c >= lo}, 8'h01, "start-up delay too short");
  endtask

  // Source pulse, reassertion in mid-delay, then cause flags
  task automatic src(input logic [3:0] s, input logic [7:0] exp);
    @(posedge clk);
    req <= s;
    #1;
    check({6'h0, core_n, port_n}, 8'h00, "reset not immediate");
    repeat (4) @(posedge clk);
    req <= 4'h0;
    repeat (8) @(posedge clk);
    req <= s;
    @(posedge clk);
    req <= 4'h0;
    wait_run(16);
    rd_chk(4'h0, exp, "cause flags");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    slow = 1'b0;
    fuse = 1'b1;
    csel = 1'b1;
    conv = 1'b0;
    kick = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    req = 4'h1;
    addr = 4'h0;
    wdata = 8'h00;
    void'($urandom(32'h1209));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    req <= 4'h0;
    wait_run(1024);
    csel <= 1'b0;
    rd_chk(4'h0, 8'h01, "power-up flag");
    wr_reg(4'h0, 8'h00);
    rd_chk(4'h0, 8'h00, "flags cleared");
    src(4'h2, 8'h02);
    src(4'h4, 8'h06);
    slow <= 1'b1;
    src(4'h8, 8'h16);
    src(4'h1, 8'h01);
    slow <= 1'b0;
    src(4'h2, 8'h03);
    rd_chk(4'hF, 8'h00, "unmapped read");
    // Prescale codes with random reserved bits
    for (i = 0; i < 8; i++) begin
      wr_reg(4'h1, (8'($urandom) & 8'hE0) | 8'h08 | 8'(i));
      rd_chk(4'h1, 8'h08 | 8'(i), "control readback");
    end
    wr_reg(4'h1, 8'h08);
    wr_reg(4'h1, 8'h00);
    rd_chk(4'h1, 8'h08, "locked clear");
    wr_reg(4'h1, 8'h18);
    repeat (6) @(posedge clk);
    wr_reg(4'h1, 8'h00);
    rd_chk(4'h1, 8'h08, "unlock expired");
    wr_reg(4'h1, 8'h18);
    wr_reg(4'h1, 8'h00);
    repeat (4) @(posedge clk);
    rd_chk(4'h1, 8'h00, "dog disabled");
    // Random reference consumers
    for (i = 0; i < 16; i++) begin
      comparator_bandgap_select = 1'($urandom);
      @(posedge clk);
      conv <= 1'($urandom);
      fuse <= 1'($urandom);
      wr_reg(4'h2, {7'h0, comparator_bandgap_select});
      rd_chk(4'h3, {6'h0, fuse | comparator_bandgap_select | conv, 1'b0}, "state");
      check({7'h0, bg}, {7'h0, fuse | comparator_bandgap_select | conv}, "bandgap");
    end
    // Reference start-up wait before use
    repeat (700) @(posedge clk);
    check({7'h0, bg}, {7'h0, fuse | comparator_bandgap_select | conv}, "settled");
    fuse <= 1'b0;
    req <= 4'h4;
    repeat (3) @(posedge clk);
    check({7'h0, core_n}, 8'h01, "unfused detector reset");
    req <= 4'h0;
    wr_reg(4'h0, 8'h00);
    // Watchdog kicked, then left to expire
    wr_reg(4'h1, 8'h08);
    repeat (15000) @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    n = 0;
    while (core_n === 1'b1 && n < 17000) begin
      @(posedge clk);
      n++;
    end
    check({7'h0, n > 16000 && n < 16500}, 8'h01, "dog period");
    n = 0;
    while (core_n !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check({7'h0, n >= 16 && n < 2000}, 8'h01, "dog delay");
    rd_chk(4'h0, 8'h08, "dog flag");
    close_out();
  end
endmodule
`default_nettype wire
